// *** hw/vtar_defines.vh ***
// Constants for the VLAN table access register bank
`ifndef VTAR_DEFINES_VH
`define VTAR_DEFINES_VH
// ==================================================
// Register offsets
`define VTAR_OFS_WORD0 16'h0400
`define VTAR_OFS_UNTAG 16'h0404
`define VTAR_OFS_FWD 16'h0408
`define VTAR_OFS_ROW 16'h040c
`define VTAR_OFS_CTRL 16'h040e
// ==================================================
// Field positions
`define VTAR_VALID_BIT 31
`define VTAR_PMS_BIT 27
`define VTAR_PRIO_HI 26
`define VTAR_PRIO_LO 24
`define VTAR_STI_HI 14
`define VTAR_STI_LO 12
`define VTAR_FDID_HI 6
`define VTAR_FDID_LO 0
`define VTAR_MASK_HI 2
`define VTAR_ROW_HI 11
`define VTAR_START_BIT 7
`define VTAR_ACT_HI 1
// ==================================================
// Action codes and states
`define VTAR_ACT_NOP 2'h0
`define VTAR_ACT_WRITE 2'h1
`define VTAR_ACT_READ 2'h2
`define VTAR_ACT_CLEAR 2'h3
`define VTAR_ST_IDLE 1'h0
`define VTAR_ST_BUSY 1'h1
`endif

// *** hw/vtar_regs.v ***
// VLAN table access register bank with table action sequencer
`timescale 1ns/1ns
`default_nettype none
`include "vtar_defines.vh"
module vtar_regs (
  input wire clk_sys,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output wire entry_valid,
  output wire port_map_select,
  output wire [2:0] priority_level,
  output wire [2:0] spanning_tree_instance,
  output wire [6:0] filter_domain_id,
  output wire [2:0] tag_strip_mask,
  input wire [2:0] other_port_map,
  output reg [2:0] egress_ports,
  output wire tbl_req,
  output wire [1:0] tbl_op,
  output wire [11:0] vlan_row_pointer,
  output wire [31:0] tbl_wr_word0,
  output wire [2:0] tbl_wr_untag,
  output wire [2:0] tbl_wr_fwd,
  input wire tbl_done,
  input wire [31:0] tbl_rd_word0,
  input wire [2:0] tbl_rd_untag,
  input wire [2:0] tbl_rd_fwd
);
  // ==================================================
  // Staging registers
  reg valid_q;
  reg pms_q;
  reg [2:0] prio_q;
  reg [2:0] sti_q;
  reg [6:0] fdid_q;
  reg [2:0] untag_q;
  reg [2:0] fwd_q;
  reg [11:0] row_q;
  reg [1:0] act_q;
  reg state_q;
  wire [31:0] word0;
  wire launch;
  wire done_now;

  // Only live fields are stored, so reserved bits read zero
  assign word0 = {valid_q, 3'h0, pms_q, prio_q, 9'h000, sti_q, 5'h00, fdid_q};

  assign entry_valid = valid_q;
  assign port_map_select = pms_q;
  assign priority_level = prio_q;
  assign spanning_tree_instance = sti_q;
  assign filter_domain_id = fdid_q;
  assign tag_strip_mask = untag_q;
  assign vlan_row_pointer = row_q;
  assign tbl_wr_word0 = word0;
  assign tbl_wr_untag = untag_q;
  assign tbl_wr_fwd = fwd_q;

  // No-op needs no table cycle and finishes at once
  assign tbl_req = (state_q == `VTAR_ST_BUSY) && (act_q != `VTAR_ACT_NOP);
  assign tbl_op = act_q;
  assign launch = reg_wr && (reg_addr == `VTAR_OFS_CTRL) && reg_wdata[`VTAR_START_BIT]
    && (state_q == `VTAR_ST_IDLE);
  assign done_now = (state_q == `VTAR_ST_BUSY) && (!tbl_req || tbl_done);

  // ==================================================
  // Egress port choice
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      egress_ports <= 3'h0;
    end else if (pms_q) begin
      egress_ports <= fwd_q;
    end else begin
      egress_ports <= other_port_map;
    end
  end

  // ==================================================
  // Action sequencer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= `VTAR_ST_IDLE;
      act_q <= `VTAR_ACT_NOP;
    end else begin
      case (state_q)
        `VTAR_ST_IDLE: begin
          // Action field is frozen while busy to keep the table op stable
          if (reg_wr && (reg_addr == `VTAR_OFS_CTRL)) begin
            act_q <= reg_wdata[`VTAR_ACT_HI:0];
          end
          if (launch) begin
            state_q <= `VTAR_ST_BUSY;
          end
        end
        `VTAR_ST_BUSY: begin
          if (done_now) begin
            state_q <= `VTAR_ST_IDLE;
          end
        end
        default: begin
          state_q <= `VTAR_ST_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // Decode helpers
  // One shared compare keeps the four staging strobe decodes identical; the control strobe compares directly
  function addr_hit;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Single flag of an entry word
  function flag_at;
    input [31:0] word;
    input integer pos;
    begin
      flag_at = word[pos];
    end
  endfunction

  // Three-bit field of an entry word
  function [2:0] field3;
    input [31:0] word;
    input integer lo;
    begin
      field3 = word[lo +: 3];
    end
  endfunction

  // Filter domain field of an entry word
  function [6:0] fdid_field;
    input [31:0] word;
    begin
      fdid_field = word[`VTAR_FDID_HI:`VTAR_FDID_LO];
    end
  endfunction

  // Port masks read back with reserved bits at zero
  function [31:0] mask_word;
    input [2:0] mask;
    begin
      mask_word = {29'h00000000, mask};
    end
  endfunction

  // ==================================================
  // Strobe decode
  wire wr_word0;
  wire wr_untag;
  wire wr_fwd;
  wire wr_row;
  wire load_rd;
  wire [31:0] row_word;
  wire [31:0] ctrl_word;

  assign wr_word0 = reg_wr && addr_hit(reg_addr, `VTAR_OFS_WORD0);
  assign wr_untag = reg_wr && addr_hit(reg_addr, `VTAR_OFS_UNTAG);
  assign wr_fwd = reg_wr && addr_hit(reg_addr, `VTAR_OFS_FWD);
  assign wr_row = reg_wr && addr_hit(reg_addr, `VTAR_OFS_ROW);
  // Table data wins over a staging write landing in the same cycle
  assign load_rd = done_now && tbl_req && (act_q == `VTAR_ACT_READ);
  assign row_word = {20'h00000, row_q};
  assign ctrl_word = {24'h000000, state_q, 5'h00, act_q};

  // ==================================================
  // Valid flag
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'b0;
    end else if (load_rd) begin
      valid_q <= flag_at(tbl_rd_word0, `VTAR_VALID_BIT);
    end else if (wr_word0) begin
      valid_q <= flag_at(reg_wdata, `VTAR_VALID_BIT);
    end
  end

  // ==================================================
  // Port map select
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pms_q <= 1'b0;
    end else if (load_rd) begin
      pms_q <= flag_at(tbl_rd_word0, `VTAR_PMS_BIT);
    end else if (wr_word0) begin
      pms_q <= flag_at(reg_wdata, `VTAR_PMS_BIT);
    end
  end

  // ==================================================
  // Priority level
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prio_q <= 3'h0;
    end else if (load_rd) begin
      prio_q <= field3(tbl_rd_word0, `VTAR_PRIO_LO);
    end else if (wr_word0) begin
      prio_q <= field3(reg_wdata, `VTAR_PRIO_LO);
    end
  end

  // ==================================================
  // Spanning tree instance
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sti_q <= 3'h0;
    end else if (load_rd) begin
      sti_q <= field3(tbl_rd_word0, `VTAR_STI_LO);
    end else if (wr_word0) begin
      sti_q <= field3(reg_wdata, `VTAR_STI_LO);
    end
  end

  // ==================================================
  // Filter domain id
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fdid_q <= 7'h00;
    end else if (load_rd) begin
      fdid_q <= fdid_field(tbl_rd_word0);
    end else if (wr_word0) begin
      fdid_q <= fdid_field(reg_wdata);
    end
  end

  // ==================================================
  // Untag mask
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      untag_q <= 3'h0;
    end else if (load_rd) begin
      untag_q <= tbl_rd_untag;
    end else if (wr_untag) begin
      untag_q <= reg_wdata[`VTAR_MASK_HI:0];
    end
  end

  // ==================================================
  // Forward mask
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fwd_q <= 3'h0;
    end else if (load_rd) begin
      fwd_q <= tbl_rd_fwd;
    end else if (wr_fwd) begin
      fwd_q <= reg_wdata[`VTAR_MASK_HI:0];
    end
  end

  // ==================================================
  // Row pointer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      row_q <= 12'h000;
    end else if (wr_row) begin
      // Row may change mid-action; software should wait for start clear
      row_q <= reg_wdata[`VTAR_ROW_HI:0];
    end
  end

  // ==================================================
  // Read data, one cycle after the strobe
  function [31:0] read_mux;
    input [15:0] addr;
    input [31:0] w0;
    input [2:0] untag;
    input [2:0] fwd;
    input [31:0] row;
    input [31:0] ctrl;
    begin
      case (addr)
        `VTAR_OFS_WORD0: read_mux = w0;
        `VTAR_OFS_UNTAG: read_mux = mask_word(untag);
        `VTAR_OFS_FWD: read_mux = mask_word(fwd);
        `VTAR_OFS_ROW: read_mux = row;
        `VTAR_OFS_CTRL: read_mux = ctrl;
        default: read_mux = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= read_mux(reg_addr, word0, untag_q, fwd_q, row_word, ctrl_word);
    end
  end
endmodule // vtar_regs
`default_nettype wire

// *** sim/vtar_regs_properties.sv ***
// Assertion checker for the VLAN table access registers
`timescale 1ns/1ns
`default_nettype none
module vtar_regs_properties (
  input wire clk_sys,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire entry_valid,
  input wire [11:0] vlan_row_pointer,
  input wire port_map_select,
  input wire [2:0] other_port_map,
  input wire [2:0] egress_ports,
  input wire [2:0] tbl_wr_fwd,
  input wire tbl_req,
  input wire [1:0] tbl_op,
  input wire tbl_done
);
  // ==================================================
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Idle only: control writes while busy are dropped
  sequence s_go;
    reg_wr && reg_addr == 16'h040e && reg_wdata[7] && reg_wdata[1:0] != 2'h0 && !tbl_req;
  endsequence
  property p_valid; reg_wr && reg_addr == 16'h0400 |=> entry_valid == $past(reg_wdata[31]); endproperty
  a_valid: assert property (p_valid) else $error("valid flag");
  property p_egress; 1'b1 |=> egress_ports == ($past(port_map_select) ? $past(tbl_wr_fwd) : $past(other_port_map)); endproperty
  a_egress: assert property (p_egress) else $error("egress ports");
  property p_row; reg_wr && reg_addr == 16'h040c |=> vlan_row_pointer == $past(reg_wdata[11:0]); endproperty
  a_row: assert property (p_row) else $error("row pointer");
  property p_launch; s_go |=> tbl_req && tbl_op == $past(reg_wdata[1:0]); endproperty
  a_launch: assert property (p_launch) else $error("launch");
  property p_done; tbl_req && tbl_done |=> !tbl_req; endproperty
  a_done: assert property (p_done) else $error("start not cleared");
  property p_hold; tbl_req && !tbl_done |=> tbl_req && $stable(tbl_op); endproperty
  a_hold: assert property (p_hold) else $error("action dropped");
  property p_resv; reg_rd && reg_addr == 16'h0404 |=> reg_rdata[31:3] == 29'h0; endproperty
  a_resv: assert property (p_resv) else $error("mask reserved");
  property p_rowresv; reg_rd && reg_addr == 16'h040c |=> reg_rdata[31:12] == 20'h0; endproperty
  a_rowresv: assert property (p_rowresv) else $error("row reserved");
endmodule // vtar_regs_properties
bind vtar_regs vtar_regs_properties u_vtar_regs_properties (.clk_sys, .nrst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .entry_valid, .vlan_row_pointer, .port_map_select,
  .other_port_map, .egress_ports, .tbl_wr_fwd, .tbl_req, .tbl_op, .tbl_done);
`default_nettype wire

// *** sim/vlan_table_access_regs_bench.sv ***
// Self-checking bench for the VLAN table access registers
`timescale 1ns/1ns
`default_nettype none
module vlan_table_access_regs_bench;
  logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tbl_done = 1'b0, tbl_req;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, tbl_rd_word0 = 32'h8100_2005, reg_rdata;
  logic [2:0] other_port_map = 3'h0, tbl_rd_untag = 3'h5, tbl_rd_fwd = 3'h2, egress_ports;
  logic [1:0] tbl_op;
  logic [11:0] vlan_row_pointer;
  logic entry_valid, port_map_select;
  logic [2:0] priority_level, spanning_tree_instance, tag_strip_mask, tbl_wr_untag, tbl_wr_fwd;
  logic [6:0] filter_domain_id;
  logic [31:0] tbl_wr_word0;
  int fail_count = 0, compares = 0;
  vtar_regs u_vtar_regs (.clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .entry_valid, .port_map_select, .priority_level, .spanning_tree_instance,
    .filter_domain_id, .tag_strip_mask, .other_port_map, .egress_ports, .tbl_req, .tbl_op,
    .vlan_row_pointer, .tbl_wr_word0, .tbl_wr_untag, .tbl_wr_fwd, .tbl_done,
    .tbl_rd_word0, .tbl_rd_untag, .tbl_rd_fwd);
  // ==================================================
  // Tasks
  initial forever #25 clk_sys = ~clk_sys;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Extra edge: read data is trusted only once it has surely landed
  task automatic rd(logic [15:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys) #1;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic act(logic [1:0] op);
    int i;
    wr(16'h040e, 32'h80 | op);
    #1;
    for (i = 0; i < 8 && tbl_req !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 8) begin
      fail_count++;
      $display("Error tbl_req expected 1 seen %b", tbl_req);
    end else begin
      chk("op", op, tbl_op);
      chk("row", 12'h5a3, vlan_row_pointer);
      rd(16'h040e, 32'h80 | op);
      @(posedge clk_sys);
      tbl_done <= 1'b1;
      @(posedge clk_sys);
      tbl_done <= 1'b0;
      rd(16'h040e, op);
    end
  endtask
  // ==================================================
  // Sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(16'h0400, 32'h0);
    rd(16'h040c, 32'h0);
    wr(16'h0400, 32'hffff_ffff);
    rd(16'h0400, 32'h8f00_707f);
    chk("valid", 1'h1, entry_valid);
    chk("map_select", 1'h1, port_map_select);
    chk("priority", 3'h7, priority_level);
    chk("sti", 3'h7, spanning_tree_instance);
    chk("fdid", 7'h7f, filter_domain_id);
    chk("wr_word0", 32'h8f00_707f, tbl_wr_word0);
    wr(16'h0404, 32'hffff_fffd);
    rd(16'h0404, 32'h5);
    chk("strip", 3'h5, tag_strip_mask);
    chk("wr_untag", 3'h5, tbl_wr_untag);
    wr(16'h0408, 32'hffff_fffb);
    rd(16'h0408, 32'h3);
    chk("wr_fwd", 3'h3, tbl_wr_fwd);
    wr(16'h040c, 32'hffff_f5a3);
    rd(16'h040c, 32'h5a3);
    rd(16'h0500, 32'h0);
    other_port_map <= 3'h6;
    repeat (2) @(posedge clk_sys) #1;
    chk("egress", 3'h3, egress_ports);
    wr(16'h0400, 32'h0);
    repeat (2) @(posedge clk_sys) #1;
    chk("egress", 3'h6, egress_ports);
    wr(16'h040e, 32'h80);
    #1 chk("busy", 1'b0, tbl_req);
    rd(16'h040e, 32'h0);
    act(2'h1);
    act(2'h3);
    act(2'h2);
    rd(16'h0400, 32'h8100_2005);
    rd(16'h0408, 32'h2);
    results;
  end
endmodule // vlan_table_access_regs_bench
`default_nettype wire
